// ### core/cpu_timer.sv
// Top of the 32-bit down-counting timer with control, debug halt and irq.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer
  import cpu_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        debug_halt,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             timer_irq,
  output logic             irq
);

  reg_req_t    req;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic        wr_hit;

  logic [31:0] count_value;
  logic [31:0] period_value;
  logic [31:0] prescale_divide;
  logic [31:0] prescale_count;
  ctrl_t       ctrl;
  logic        zero_flag;
  logic        irq_status;
  logic        irq_mask;

  logic [31:0] next_count_value;
  logic [31:0] next_period_value;
  logic [31:0] next_prescale_divide;
  logic [31:0] next_prescale_count;
  ctrl_t       next_ctrl;
  logic        next_zero_flag;
  logic        next_irq_status;
  logic        next_irq_mask;
  logic        next_timer_irq;
  logic        next_irq;

  logic        halted;
  logic        running;
  logic        tick;
  logic        hit_zero;
  logic        reload_now;
  logic        wr_ctrl;

  logic        wr_count;
  logic        wr_period;
  logic        wr_divide;
  logic        wr_prescale;
  logic        wr_status;
  logic        wr_mask;

  // ----------------------------------------------------------------------
  // Bus slave and halt logic
  // ----------------------------------------------------------------------
  cpu_timer_axil u_axil (
    .clk       (clk),
    .arst_n    (arst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .req       (req),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit),
    .wr_hit    (wr_hit)
  );

  // The halt block watches the same tick that decrements the count.
  cpu_timer_halt u_halt (
    .clk        (clk),
    .arst_n     (arst_n),
    .debug_halt (debug_halt),
    .free_run   (ctrl.free_run),
    .soft_stop  (ctrl.soft_stop),
    .decrement  (tick),
    .hit_zero   (hit_zero),
    .halted     (halted)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Only the seven whole-word offsets answer; any other address is refused.
  function automatic logic mapped(input logic [7:0] addr);
    return addr == ADDR_COUNT_VALUE || addr == ADDR_PERIOD_VALUE ||
           addr == ADDR_TIMER_CONTROL || addr == ADDR_PRESCALE_DIVIDE ||
           addr == ADDR_PRESCALE_COUNT || addr == ADDR_IRQ_STATUS ||
           addr == ADDR_IRQ_MASK;
  endfunction

  assign wr_hit      = mapped(req.wr_addr);
  assign rd_hit      = mapped(s_araddr);
  assign wr_ctrl     = req.wr_en && req.wr_addr == ADDR_TIMER_CONTROL;
  assign wr_count    = req.wr_en && req.wr_addr == ADDR_COUNT_VALUE;
  assign wr_period   = req.wr_en && req.wr_addr == ADDR_PERIOD_VALUE;
  assign wr_divide   = req.wr_en && req.wr_addr == ADDR_PRESCALE_DIVIDE;
  assign wr_prescale = req.wr_en && req.wr_addr == ADDR_PRESCALE_COUNT;
  assign wr_status   = req.wr_en && req.wr_addr == ADDR_IRQ_STATUS;
  assign wr_mask     = req.wr_en && req.wr_addr == ADDR_IRQ_MASK;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (s_araddr == ADDR_COUNT_VALUE)
      rd_data = count_value;
    else if (s_araddr == ADDR_PERIOD_VALUE)
      rd_data = period_value;
    else if (s_araddr == ADDR_TIMER_CONTROL)
    begin
      rd_data[BIT_ZERO_FLAG]       = zero_flag;
      rd_data[BIT_ZERO_IRQ_ENABLE] = ctrl.zero_irq_enable;
      rd_data[BIT_FREE_RUN]        = ctrl.free_run;
      rd_data[BIT_SOFT_STOP]       = ctrl.soft_stop;
      rd_data[BIT_STOP_CONTROL]    = ctrl.stop_control;
      // The reload request is a strobe and never reads back as set.
      rd_data[BIT_RELOAD_REQUEST]  = 1'b0;
    end
    else if (s_araddr == ADDR_PRESCALE_DIVIDE)
      rd_data = prescale_divide;
    else if (s_araddr == ADDR_PRESCALE_COUNT)
      rd_data = prescale_count;
    else if (s_araddr == ADDR_IRQ_STATUS)
      rd_data[0] = irq_status;
    else if (s_araddr == ADDR_IRQ_MASK)
      rd_data[0] = irq_mask;
  end

  // ----------------------------------------------------------------------
  // Counter datapath
  // ----------------------------------------------------------------------
  function automatic logic is_zero(input logic [31:0] value);
    return value == 32'h0000_0000;
  endfunction

  function automatic logic [31:0] minus_one(input logic [31:0] value);
    return value - 32'h0000_0001;
  endfunction

  // Counting pauses while the timer is stopped or held at a breakpoint.
  assign running    = !ctrl.stop_control && !halted;
  assign tick       = running && is_zero(prescale_count);
  // The flag marks a decrement from one, never a reload from zero.
  assign hit_zero   = tick && count_value == 32'h0000_0001;
  assign reload_now = wr_ctrl && req.wr_data[BIT_RELOAD_REQUEST];

  always_comb
  begin
    next_count_value    = count_value;
    next_prescale_count = prescale_count;
    next_period_value   = period_value;
    next_prescale_divide = prescale_divide;
    if (wr_period)
      next_period_value = req.wr_data;
    if (wr_divide)
      next_prescale_divide = req.wr_data;
    if (running)
    begin
      if (tick)
      begin
        next_prescale_count = prescale_divide;
        // A zero count reloads at the following prescaler tick.
        if (is_zero(count_value))
          next_count_value = period_value;
        else
          next_count_value = minus_one(count_value);
      end
      else
        next_prescale_count = minus_one(prescale_count);
    end
    if (wr_count)
      next_count_value = req.wr_data;
    if (wr_prescale)
      next_prescale_count = req.wr_data;
    // A reload request overrides a direct count write in the same cycle.
    if (reload_now)
    begin
      next_count_value    = period_value;
      next_prescale_count = prescale_divide;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_value     <= RESET_COUNT_VALUE;
      period_value    <= RESET_PERIOD_VALUE;
      prescale_divide <= RESET_PRESCALE_DIVIDE;
      prescale_count  <= RESET_PRESCALE_COUNT;
    end
    else
    begin
      count_value     <= next_count_value;
      period_value    <= next_period_value;
      prescale_divide <= next_prescale_divide;
      prescale_count  <= next_prescale_count;
    end
  end

  // ----------------------------------------------------------------------
  // Control, flag and interrupt state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_ctrl       = ctrl;
    next_zero_flag  = zero_flag;
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    if (wr_ctrl)
    begin
      next_ctrl.zero_irq_enable = req.wr_data[BIT_ZERO_IRQ_ENABLE];
      next_ctrl.free_run        = req.wr_data[BIT_FREE_RUN];
      next_ctrl.soft_stop       = req.wr_data[BIT_SOFT_STOP];
      next_ctrl.stop_control    = req.wr_data[BIT_STOP_CONTROL];
      // A one clears the flag; a zero leaves it as it is.
      if (req.wr_data[BIT_ZERO_FLAG])
        next_zero_flag = 1'b0;
    end
    if (wr_status && req.wr_data[0])
      next_irq_status = 1'b0;
    if (wr_mask)
      next_irq_mask = req.wr_data[0];
    // Setting wins over a clear arriving in the same cycle.
    if (hit_zero)
    begin
      next_zero_flag  = 1'b1;
      next_irq_status = 1'b1;
    end
    // Both lines use next values so they rise with the flag they follow.
    next_timer_irq = next_zero_flag && next_ctrl.zero_irq_enable;
    next_irq       = next_irq_status && next_irq_mask;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl       <= '0;
      zero_flag  <= 1'b0;
      irq_status <= 1'b0;
      irq_mask   <= 1'b0;
      timer_irq  <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      ctrl       <= next_ctrl;
      zero_flag  <= next_zero_flag;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      timer_irq  <= next_timer_irq;
      irq        <= next_irq;
    end
  end

endmodule // cpu_timer
`default_nettype wire

// ### core/cpu_timer_axil.sv
// AXI4-Lite slave front end turning bus transfers into register strobes.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer_axil
  import cpu_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output reg_req_t         req,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic [7:0]  next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic        do_write;

  // ----------------------------------------------------------------------
  // Channel handshakes
  // ----------------------------------------------------------------------
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign do_write  = aw_held && w_held && !s_bvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_bvalid;
    next_bresp   = s_bresp;
    next_rvalid  = s_rvalid;
    next_rresp   = s_rresp;
    next_rdata   = s_rdata;
    req          = '0;
    if (s_awvalid && s_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    // Partial strobes are refused; the registers only take whole words.
    if (do_write)
    begin
      req.wr_en    = (w_strb == 4'hf);
      req.wr_addr  = aw_addr;
      req.wr_data  = w_data;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_hit && w_strb == 4'hf) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_bvalid && s_bready)
      next_bvalid = 1'b0;
    if (s_arvalid && s_arready)
    begin
      req.rd_en   = 1'b1;
      req.rd_addr = s_araddr;
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_rvalid && s_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_held  <= 1'b0;
      aw_addr  <= 8'h00;
      w_held   <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp  <= RESP_OKAY;
      s_rdata  <= 32'h0000_0000;
    end
    else
    begin
      aw_held  <= next_aw_held;
      aw_addr  <= next_aw_addr;
      w_held   <= next_w_held;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      s_bvalid <= next_bvalid;
      s_bresp  <= next_bresp;
      s_rvalid <= next_rvalid;
      s_rresp  <= next_rresp;
      s_rdata  <= next_rdata;
    end
  end

endmodule // cpu_timer_axil
`default_nettype wire

// ### core/cpu_timer_halt.sv
// Breakpoint halt decision for the free-run, soft-stop and hard-stop modes.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer_halt
  import cpu_timer_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic debug_halt,
  input  wire logic free_run,
  input  wire logic soft_stop,
  input  wire logic decrement,
  input  wire logic hit_zero,
  output logic      halted
);

  halt_mode_t mode;
  logic       next_halted;

  assign mode = halt_mode(free_run, soft_stop);

  // Halting latches at the deciding decrement and releases with debug_halt.
  always_comb
  begin
    next_halted = halted;
    if (!debug_halt)
      next_halted = 1'b0;
    else
    begin
      case (mode)
        HALT_NONE: next_halted = 1'b0;
        HALT_HARD: if (decrement) next_halted = 1'b1;
        HALT_SOFT: if (hit_zero) next_halted = 1'b1;
        default:   next_halted = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      halted <= 1'b0;
    else
      halted <= next_halted;
  end

endmodule // cpu_timer_halt
`default_nettype wire

// ### core/cpu_timer_pkg.sv
// Package with register map, field positions and types of the timer block.
package cpu_timer_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT_VALUE     = 8'h00;
  localparam logic [7:0] ADDR_PERIOD_VALUE    = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE_DIVIDE = 8'h0c;
  localparam logic [7:0] ADDR_PRESCALE_COUNT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK        = 8'h18;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_ZERO_FLAG       = 15;
  localparam int BIT_ZERO_IRQ_ENABLE = 14;
  localparam int BIT_FREE_RUN        = 11;
  localparam int BIT_SOFT_STOP       = 10;
  localparam int BIT_RELOAD_REQUEST  = 5;
  localparam int BIT_STOP_CONTROL    = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RESET_COUNT_VALUE     = 32'h0000_0000;
  localparam logic [31:0] RESET_PERIOD_VALUE    = 32'h0000_ffff;
  localparam logic [31:0] RESET_PRESCALE_DIVIDE = 32'h0000_0000;
  localparam logic [31:0] RESET_PRESCALE_COUNT  = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        zero_irq_enable;
    logic        free_run;
    logic        soft_stop;
    logic        stop_control;
  } ctrl_t;

  typedef struct packed {
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        rd_en;
    logic [7:0]  rd_addr;
  } reg_req_t;

  typedef enum logic [1:0] {
    HALT_NONE = 2'b00,
    HALT_HARD = 2'b01,
    HALT_SOFT = 2'b10
  } halt_mode_t;

  // Chooses the breakpoint behaviour from the two debug bits.
  function automatic halt_mode_t halt_mode(input logic free_run,
                                           input logic soft_stop);
    if (free_run)
      return HALT_NONE;
    else if (soft_stop)
      return HALT_SOFT;
    else
      return HALT_HARD;
  endfunction

endpackage

// ### dv/cpu_timer_dbg_model.sv
// Debugger model that holds the processor at a breakpoint on request.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer_dbg_model
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic want,
  output logic      debug_halt
);
  // The breakpoint line follows the request one clock later.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      debug_halt <= 1'b0;
    else
      debug_halt <= want;
  end
endmodule // cpu_timer_dbg_model
`default_nettype wire

// ### dv/cpu_timer_properties.sv
// Checker of bus handshakes and control read-back at the timer's ports.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer_props
  import cpu_timer_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic [3:0]  s_wstrb,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [7:0]  s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic        timer_irq,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic [7:0] rd_addr;
  logic [7:0] next_rd_addr;
  logic       strb_bad;
  logic       next_strb_bad;

  // Remembers what the answer in flight belongs to.
  always_comb
  begin
    next_rd_addr = (s_arvalid && s_arready) ? s_araddr : rd_addr;
    next_strb_bad = (s_wvalid && s_wready) ? (s_wstrb != 4'hf) : strb_bad;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_addr <= 8'h00;
      strb_bad <= 1'b0;
    end
    else
    begin
      rd_addr <= next_rd_addr;
      strb_bad <= next_strb_bad;
    end
  end

  a_bvalid_stands: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("bvalid dropped before bready");
  a_rdata_stands: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata)) else $error("read answer changed");
  a_write_busy: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
  a_read_busy: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answer pending");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |-> ##[1:2] s_bvalid) else $error("write response late");
  a_unmapped_read: assert property (s_arvalid && s_arready &&
    s_araddr > ADDR_IRQ_MASK |=> s_rresp == RESP_SLVERR &&
    s_rdata == 32'h0) else $error("unmapped read not refused");
  a_ctrl_reserved: assert property (s_rvalid &&
    rd_addr == ADDR_TIMER_CONTROL |-> (s_rdata & 32'hffff_33ef) == 32'h0)
    else $error("control reads back reserved or reload bits");
  a_strobe_refused: assert property (s_bvalid && strb_bad |->
    s_bresp == RESP_SLVERR) else $error("partial write accepted");

  c_timer_irq: cover property ($rose(timer_irq));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_rvalid && s_rresp == RESP_SLVERR);
endmodule // cpu_timer_props

bind cpu_timer cpu_timer_props u_props (.clk, .arst_n, .s_awvalid,
  .s_awready, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
  .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
  .s_rvalid, .s_rready, .timer_irq, .irq);
`default_nettype wire

// ### dv/cpu_timer_tb_top.sv
// Self-checking testbench of the timer over its register bus.
`timescale 1ns/10ps
`default_nettype none
module cpu_timer_tb_top;
  import cpu_timer_pkg::*;
  logic clk, arst_n, debug_halt, want, timer_irq, irq;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int num_errors = 0;
  int cmp_count = 0;

  cpu_timer uut (.clk, .arst_n, .debug_halt, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .timer_irq, .irq);
  cpu_timer_dbg_model u_dbg (.clk, .arst_n, .want, .debug_halt);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= s;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_awvalid && s_awready)
        s_awvalid <= 1'b0;
      if (s_wvalid && s_wready)
        s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1)
      begin
        r = s_bresp;
        s_bready <= 1'b0;
        return;
      end
    end
    num_errors++;
    results();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_arvalid && s_arready)
        s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1)
      begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        return;
      end
    end
    num_errors++;
    results();
  endtask

  task automatic s_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d, 32'h0);
    rd(ADDR_PERIOD_VALUE, d, r);
    chk(d, RESET_PERIOD_VALUE);
    rd(8'h1c, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(ADDR_PERIOD_VALUE, 32'h1, 4'h3, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(ADDR_PERIOD_VALUE, d, r);
    chk(d, RESET_PERIOD_VALUE);
  endtask

  task automatic s_reload();
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_TIMER_CONTROL, 32'h10, 4'hf, r);
    wr(ADDR_PERIOD_VALUE, 32'h5, 4'hf, r);
    wr(ADDR_PRESCALE_DIVIDE, 32'h2, 4'hf, r);
    wr(ADDR_TIMER_CONTROL, 32'h30, 4'hf, r);
    rd(ADDR_COUNT_VALUE, d, r);
    chk(d, 32'h5);
    rd(ADDR_PRESCALE_COUNT, d, r);
    chk(d, 32'h2);
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d, 32'h10);
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT_VALUE, d, r);
    chk(d, 32'h5);
    wr(ADDR_TIMER_CONTROL, 32'h0, 4'hf, r);
    repeat (5) @(posedge clk);
    wr(ADDR_TIMER_CONTROL, 32'h10, 4'hf, r);
    rd(ADDR_COUNT_VALUE, d, r);
    chk(d, 32'h2);
    rd(ADDR_PRESCALE_COUNT, d, r);
    chk(d, 32'h2);
  endtask

  task automatic s_zero_irq();
    logic [31:0] d;
    logic [1:0]  r;
    int n;
    wr(ADDR_IRQ_MASK, 32'h1, 4'hf, r);
    wr(ADDR_TIMER_CONTROL, 32'h4000, 4'hf, r);
    for (n = 0; n < 100 && timer_irq !== 1'b1; n++)
      @(posedge clk);
    chk({31'h0, timer_irq}, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d & 32'hc010, 32'hc000);
    wr(ADDR_TIMER_CONTROL, 32'h4010, 4'hf, r);
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d, 32'hc010);
    wr(ADDR_TIMER_CONTROL, 32'hc010, 4'hf, r);
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d, 32'h4010);
    chk({31'h0, timer_irq}, 32'h0);
    rd(ADDR_IRQ_STATUS, d, r);
    chk(d, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1, 4'hf, r);
    rd(ADDR_IRQ_STATUS, d, r);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_TIMER_CONTROL, 32'h0, 4'hf, r);
    repeat (60) @(posedge clk);
    chk({31'h0, timer_irq}, 32'h0);
    rd(ADDR_TIMER_CONTROL, d, r);
    chk(d, 32'h8000);
  endtask

  task automatic s_debug();
    logic [31:0] a, b, ctl;
    logic [1:0]  r;
    wr(ADDR_PRESCALE_DIVIDE, 32'h0, 4'hf, r);
    for (int i = 0; i < 3; i++)
    begin
      ctl = (i == 0) ? 32'h0800 : (i == 1) ? 32'h0000 : 32'h4400;
      wr(ADDR_PERIOD_VALUE, (i == 2) ? 32'h20 : 32'h1000, 4'hf, r);
      wr(ADDR_TIMER_CONTROL, ctl | 32'h8030, 4'hf, r);
      wr(ADDR_TIMER_CONTROL, ctl, 4'hf, r);
      rd(ADDR_COUNT_VALUE, a, r);
      rd(ADDR_COUNT_VALUE, b, r);
      chk({31'h0, a != b}, 32'h1);
      want <= 1'b1;
      repeat (60) @(posedge clk);
      rd(ADDR_COUNT_VALUE, a, r);
      rd(ADDR_COUNT_VALUE, b, r);
      if (i == 0)
        chk({31'h0, a != b}, 32'h1);
      else if (i == 1)
        chk({31'h0, a == b}, 32'h1);
      else
        chk({b, timer_irq}, {a, 1'b1});
      if (i == 2)
        chk(a, 32'h0);
      want <= 1'b0;
      repeat (4) @(posedge clk);
      rd(ADDR_COUNT_VALUE, a, r);
      rd(ADDR_COUNT_VALUE, b, r);
      chk({31'h0, a != b}, 32'h1);
    end
  endtask

  initial
  begin
    arst_n = 1'b0;
    want = 1'b0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
    s_reload();
    s_zero_irq();
    s_debug();
    results();
  end
endmodule // cpu_timer_tb_top
`default_nettype wire
